// file: src/autobaud_pkg.sv
// shared constants and types for the auto-baud and wake-on-break block
package autobaud_pkg;

  // measurement clock dividers in core clocks: base clock times eight
  localparam int unsigned ABD_DIV_00    = 512;
  localparam int unsigned ABD_DIV_01    = 128;
  localparam int unsigned ABD_DIV_10    = 128;
  localparam int unsigned ABD_DIV_11    = 32;
  localparam int unsigned PRESCALE_W    = 9;

  // sync character layout
  localparam logic [7:0]  SYNC_CHAR     = 8'h55;
  localparam logic [2:0]  RISE_COUNT    = 3'h5;
  localparam logic [15:0] COUNT_START   = 16'h0001;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;

  // receive line synchroniser depth
  localparam int unsigned SYNC_STAGES   = 3;

  // auto-baud sequence states
  typedef enum logic [1:0] {
    ABD_IDLE,
    ABD_WAIT_START,
    ABD_WAIT_FIRST,
    ABD_COUNT
  } abd_state_type;

endpackage

// file: src/line_sync.sv
// three-stage synchroniser for the receive line with edge detection
`timescale 1ns/1ns
module line_sync
  import autobaud_pkg::*;
(
  input  wire logic ref_clk_i,   // core clock
  input  wire logic reset_i,     // async reset, active high
  input  wire logic line_i,      // raw receive pin
  output logic      level_o,     // filtered line level
  output logic      rise_o,      // one-cycle rising edge
  output logic      fall_o       // one-cycle falling edge
);

  typedef struct packed {
    logic [SYNC_STAGES-1:0] stage;
    logic                   level;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  // a change counts only once stages two and three agree
  always_comb begin
    next_state       = state;
    next_state.stage = {state.stage[SYNC_STAGES-2:0], line_i};
    if (state.stage[1] == state.stage[2]) begin
      next_state.level = state.stage[2];
    end
  end

  // idle line is high, so reset to high avoids a false edge
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '{stage: '1, level: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign level_o = state.level;
  assign rise_o  = next_state.level & ~state.level;
  assign fall_o  = ~next_state.level & state.level;

endmodule

// file: src/abd_prescaler.sv
// divider producing the one-eighth base clock enable for measurement
`timescale 1ns/1ns
module abd_prescaler
  import autobaud_pkg::*;
(
  input  wire logic       ref_clk_i,            // core clock
  input  wire logic       reset_i,              // async reset, active high
  input  wire logic       run_i,                // counting enabled
  input  wire logic       wide_divider_select_i, // divider width select
  input  wire logic       high_speed_select_i,  // high speed select
  output logic            tick_o                // one-cycle enable pulse
);

  typedef struct packed {
    logic [PRESCALE_W-1:0] count;
  } pre_state_type;

  pre_state_type         state;
  pre_state_type         next_state;
  logic [PRESCALE_W-1:0] last;

  // terminal count from the mode select
  always_comb begin
    unique case ({wide_divider_select_i, high_speed_select_i})
      2'b00: last = PRESCALE_W'(ABD_DIV_00 - 1);
      2'b01: last = PRESCALE_W'(ABD_DIV_01 - 1);
      2'b10: last = PRESCALE_W'(ABD_DIV_10 - 1);
      2'b11: last = PRESCALE_W'(ABD_DIV_11 - 1);
    endcase
  end

  // restarted whenever measurement is not running
  always_comb begin
    next_state = state;
    if (!run_i || state.count >= last) begin
      next_state.count = '0;
    end else begin
      next_state.count = state.count + PRESCALE_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '{count: '0};
    end else begin
      state <= next_state;
    end
  end

  assign tick_o = run_i && (state.count >= last);

endmodule

// file: src/autobaud_wake.sv
// auto-baud measurement and wake-on-break control beside the receiver
`timescale 1ns/1ns
// How it works
// - receiver held idle while measuring
// - times sync 55h across five rising edges
// - counting starts at first rise after start
// - fifth rise: keep count, clear enable, flag
// - data read clears receive flag
// - both divider bytes form one counter
// - count at one eighth base clock
// - counter begins at one
// - with wake, measure byte after break
// - overflow flag past sixteen bits
// - after overflow keep counting to fifth rise
// - overflow clear only while enable clear
// - wake only in asynchronous mode
// - wake: reception off, falling edge wakes
// - flag synchronous awake, asynchronous asleep
// - rising edge ends break, clears wake enable
// - non-zero character: first low is wake
module autobaud_wake
  import autobaud_pkg::*;
(
  input  wire logic        ref_clk_i,               // core clock, 20 MHz
  input  wire logic        reset_i,                 // async reset, active high
  input  wire logic        receive_line_i,          // raw receive pin
  input  wire logic        sleep_i,                 // core clock stopped
  input  wire logic        sync_mode_i,             // synchronous mode select
  input  wire logic        wide_divider_select_i,   // divider width select
  input  wire logic        high_speed_select_i,     // high speed select
  input  wire logic        autobaud_enable_set_i,   // pulse: start measurement
  input  wire logic        autobaud_enable_clr_i,   // pulse: abort measurement
  input  wire logic        overflow_clr_i,          // pulse: clear overflow flag
  input  wire logic        wake_enable_set_i,       // pulse: arm wake-on-break
  input  wire logic        wake_enable_clr_i,       // pulse: disarm wake
  input  wire logic        divider_write_i,         // pulse: load divider pair
  input  wire logic [15:0] divider_wdata_i,         // divider write data
  input  wire logic        receive_data_read_i,     // pulse: data register read
  input  wire logic        receiver_flag_set_i,     // pulse: receiver got char
  input  wire logic        receiver_idle_i,         // receiver shift engine idle
  output logic             autobaud_enable_o,       // measurement in progress
  output logic             autobaud_overflow_flag_o, // counter overflowed
  output logic             wake_on_break_enable_o,  // wake armed
  output logic             receive_flag_o,          // receive flag
  output logic             receive_hold_idle_o,     // hold receiver idle
  output logic             receive_idle_flag_o,     // no reception in progress
  output logic [7:0]       divider_high_byte_o,     // divider high byte
  output logic [7:0]       divider_low_byte_o       // divider low byte
);

  typedef struct packed {
    abd_state_type state;
    logic          abd_en;
    logic          ovf;
    logic          wake_on_break_enable;
    logic          rcv_flag;
    logic          wake_latched;
    logic [2:0]    rises;
    logic [15:0]   divider;
  } ctl_state_type;

  ctl_state_type r;
  ctl_state_type next_r;
  logic          line_level;
  logic          line_rise;
  logic          line_fall;
  logic          abd_tick;
  logic          counting;
  logic          wake_async_q;
  logic          wake_async_meta;
  logic          wake_async_seen;
  logic          latch_clear;
  logic [16:0]   count_sum;

  // line synchronised before every edge decision except the sleep wake latch on the raw pin
  line_sync u_line_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .line_i    (receive_line_i),
    .level_o   (line_level),
    .rise_o    (line_rise),
    .fall_o    (line_fall)
  );

  // prescaler gives eighth-of-base tick while counting
  assign counting = (r.state == ABD_COUNT);

  abd_prescaler u_abd_prescaler (
    .ref_clk_i             (ref_clk_i),
    .reset_i               (reset_i),
    .run_i                 (counting),
    .wide_divider_select_i (wide_divider_select_i),
    .high_speed_select_i   (high_speed_select_i),
    .tick_o                (abd_tick)
  );

  // with the core clock stopped a falling pin edge is caught by a latch
  // clocked by the pin itself; the core later resynchronises it
  // dropped together with the wake enable, else a stale event would
  // fire again the next time wake is armed
  assign latch_clear = reset_i | ~r.wake_on_break_enable;

  always_ff @(negedge receive_line_i or posedge latch_clear) begin
    if (latch_clear) begin
      wake_async_q <= 1'b0;
    end else begin
      wake_async_q <= sleep_i & r.wake_on_break_enable & ~sync_mode_i;
    end
  end

  // two flops bring the sleep wake event into the core domain
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_async_meta <= 1'b0;
      wake_async_seen <= 1'b0;
    end else begin
      wake_async_meta <= wake_async_q;
      wake_async_seen <= wake_async_meta;
    end
  end

  // full 17-bit add so the carry marks the sixteen-bit overflow
  assign count_sum = {1'b0, r.divider} + 17'h00001;

  // main control: measurement sequence, wake handling, flags
  always_comb begin
    next_r = r;

    // software writes to the divider only stick outside measurement
    if (divider_write_i && !r.abd_en) begin
      next_r.divider = divider_wdata_i;
    end

    // data register read clears the flag, but a new set wins
    if (receive_data_read_i) begin
      next_r.rcv_flag = 1'b0;
    end
    if (receiver_flag_set_i && !r.abd_en && !r.wake_on_break_enable) begin
      next_r.rcv_flag = 1'b1;
    end

    // wake arming; synchronous mode has no wake function
    if (wake_enable_set_i && !sync_mode_i) begin
      next_r.wake_on_break_enable          = 1'b1;
      next_r.wake_latched = 1'b0;
    end
    if (wake_enable_clr_i) begin
      next_r.wake_on_break_enable = 1'b0;
    end

    // wake: first falling edge is the event, whatever the character
    if (r.wake_on_break_enable && !r.wake_latched && (line_fall || wake_async_seen)) begin
      next_r.wake_latched = 1'b1;
      next_r.rcv_flag     = 1'b1;
    end

    // the rise ending the break disarms wake, unit waits idle
    if (r.wake_on_break_enable && (r.wake_latched || wake_async_seen) && line_rise) begin
      next_r.wake_on_break_enable          = 1'b0;
      next_r.wake_latched = 1'b0;
    end

    // measurement start request
    if (autobaud_enable_set_i) begin
      next_r.abd_en = 1'b1;
      next_r.state  = ABD_WAIT_START;
      next_r.rises  = '0;
    end

    // auto-baud sequence on the synchronised line
    unique case (r.state)
      ABD_IDLE: begin
      end
      ABD_WAIT_START: begin
        // while wake is armed the break is skipped
        if (!r.wake_on_break_enable && !next_r.wake_on_break_enable && line_fall) begin
          next_r.state = ABD_WAIT_FIRST;
        end
      end
      ABD_WAIT_FIRST: begin
        // first rise after the start bit begins the count
        if (line_rise) begin
          next_r.state   = ABD_COUNT;
          next_r.rises   = 3'h1;
          next_r.divider = COUNT_START;
        end
      end
      ABD_COUNT: begin
        if (abd_tick) begin
          next_r.divider = count_sum[15:0];
          if (count_sum[16]) begin
            next_r.ovf = 1'b1;
          end
        end
        if (line_rise) begin
          next_r.rises = r.rises + 3'h1;
          if (r.rises + 3'h1 == RISE_COUNT) begin
            // count left in the divider pair
            next_r.state    = ABD_IDLE;
            next_r.abd_en   = 1'b0;
            next_r.rcv_flag = 1'b1;
          end
        end
      end
    endcase

    // software abort; overflow clear needs enable already clear
    if (autobaud_enable_clr_i) begin
      next_r.abd_en = 1'b0;
      next_r.state  = ABD_IDLE;
    end
    if (overflow_clr_i && !r.abd_en) begin
      next_r.ovf = 1'b0;
    end
  end

  // single register of all control state
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= '{state: ABD_IDLE, abd_en: 1'b0, ovf: 1'b0, wake_on_break_enable: 1'b0,
             rcv_flag: 1'b0, wake_latched: 1'b0, rises: 3'h0,
             divider: DIVIDER_RESET};
    end else begin
      r <= next_r;
    end
  end

  // sleep event raises the flag asynchronously, before the core wakes
  assign receive_flag_o           = r.rcv_flag | (wake_async_q & r.wake_on_break_enable);
  assign autobaud_enable_o        = r.abd_en;
  assign autobaud_overflow_flag_o = r.ovf;
  assign wake_on_break_enable_o   = r.wake_on_break_enable;
  // receiver idle during measurement and while wake armed
  assign receive_hold_idle_o      = r.abd_en | r.wake_on_break_enable;
  assign receive_idle_flag_o      = receiver_idle_i & ~r.abd_en;
  // high byte reads zero only while the count stays below 256, in every mode
  assign divider_high_byte_o      = r.divider[15:8];
  assign divider_low_byte_o       = r.divider[7:0];

endmodule

// file: sim/remote_tx.sv
// remote serial sender model driving the receive line
`timescale 1ns/1ns
module remote_tx (
  input  wire logic ref_clk_i, // bench clock
  output logic      line_o     // serial line, idle high
);
  initial line_o = 1'b1;

  // one level held for bt core clocks, changed on falling edges
  task automatic bit_out(input logic v, input int bt);
    @(negedge ref_clk_i) line_o = v;
    repeat (bt - 1) @(negedge ref_clk_i);
  endtask

  // start, eight data bits lsb first, then stop plus one idle bit
  task automatic send(input logic [7:0] b, input int bt);
    bit_out(1'b0, bt);
    for (int i = 0; i < 8; i++) bit_out(b[i], bt);
    bit_out(1'b1, 2 * bt);
  endtask

  // all-zero wake character; a short one would wake the far end too early
  task automatic brk(input int bits, input int bt);
    bit_out(1'b0, (bits < 10 ? 10 : bits) * bt);
    bit_out(1'b1, bt);
  endtask
endmodule

// file: sim/autobaud_wake_asserts.sv
// concurrent checks on the auto-baud and wake ports
`timescale 1ns/1ns
module autobaud_wake_asserts
  import autobaud_pkg::*;
(
  input wire logic       ref_clk_i,                // clock
  input wire logic       reset_i,                  // reset
  input wire logic       receive_line_i,           // pin
  input wire logic       sleep_i,                  // asleep
  input wire logic       sync_mode_i,              // sync mode
  input wire logic       autobaud_enable_set_i,    // start
  input wire logic       autobaud_enable_clr_i,    // abort
  input wire logic       overflow_clr_i,           // ovf clear
  input wire logic       wake_enable_set_i,        // arm wake
  input wire logic       divider_write_i,          // load
  input wire logic       receive_data_read_i,      // read
  input wire logic       receiver_flag_set_i,      // rx set
  input wire logic       autobaud_enable_o,        // measuring
  input wire logic       autobaud_overflow_flag_o, // ovf
  input wire logic       wake_on_break_enable_o,   // wake armed
  input wire logic       receive_flag_o,           // flag
  input wire logic       receive_hold_idle_o,      // hold idle
  input wire logic [7:0] divider_high_byte_o,      // high byte
  input wire logic [7:0] divider_low_byte_o        // low byte
);
  wire logic [15:0] div = {divider_high_byte_o, divider_low_byte_o};

  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // control outputs against their causes
  hold_idle_a: assert property (
    receive_hold_idle_o == (autobaud_enable_o | wake_on_break_enable_o)) else $error("hold idle");
  abort_a: assert property (
    autobaud_enable_clr_i |=> !autobaud_enable_o) else $error("abort ignored");
  ovf_keep_a: assert property (
    overflow_clr_i && autobaud_enable_o && autobaud_overflow_flag_o |=> autobaud_overflow_flag_o)
    else $error("overflow cleared while measuring");
  ovf_rise_a: assert property (
    $rose(autobaud_overflow_flag_o) |-> $past(autobaud_enable_o)) else $error("stray overflow");
  done_flag_a: assert property (
    $fell(autobaud_enable_o) && !$past(autobaud_enable_clr_i) |-> receive_flag_o)
    else $error("no flag at completion");
  div_count_a: assert property (
    autobaud_enable_o && !$stable(div)
      |-> (div == $past(div) + 16'h0001) || (div == COUNT_START) || (div == DIVIDER_RESET))
    else $error("divider step wrong");
  div_hold_a: assert property (
    !autobaud_enable_o && !autobaud_enable_set_i && !divider_write_i |=> $stable(div))
    else $error("divider moved while idle");
  wake_sync_a: assert property (
    sync_mode_i && wake_enable_set_i && !wake_on_break_enable_o |=> !wake_on_break_enable_o)
    else $error("wake armed in sync mode");
  wake_flag_a: assert property (
    wake_on_break_enable_o && $fell(receive_line_i) |-> ##[1:6] receive_flag_o)
    else $error("no wake flag");
  wake_end_a: assert property (
    wake_on_break_enable_o && $rose(receive_line_i) |-> ##[1:6] !wake_on_break_enable_o)
    else $error("wake not cleared");
  read_clr_a: assert property (
    receive_data_read_i && !receiver_flag_set_i && !receive_hold_idle_o && !sleep_i
      |=> !receive_flag_o) else $error("read kept flag");

  // main scenarios reached
  cover property ($fell(autobaud_enable_o) && receive_flag_o);
  cover property ($fell(wake_on_break_enable_o));
  cover property (sleep_i && receive_flag_o);
endmodule

bind autobaud_wake autobaud_wake_asserts u_autobaud_wake_asserts (.*);

// file: sim/test_autobaud_wake.sv
// self-checking bench for the auto-baud and wake block
`timescale 1ns/1ns
module test_autobaud_wake
  import autobaud_pkg::*;
;
  logic        ref_clk_i, reset_i, sleep_i, sync_mode_i, receiver_idle_i;
  logic        wide_divider_select_i, high_speed_select_i;
  logic [15:0] divider_wdata_i;
  logic [7:0]  p;
  logic        autobaud_enable_o, autobaud_overflow_flag_o, wake_on_break_enable_o;
  logic        receive_flag_o, receive_hold_idle_o, receive_idle_flag_o;
  logic [7:0]  divider_high_byte_o, divider_low_byte_o;
  wire logic   receive_line_i;
  // pulse inputs share one vector so a single task drives them
  wire logic   autobaud_enable_set_i = p[0];
  wire logic   autobaud_enable_clr_i = p[1];
  wire logic   overflow_clr_i        = p[2];
  wire logic   wake_enable_set_i     = p[3];
  wire logic   wake_enable_clr_i     = p[4];
  wire logic   divider_write_i       = p[5];
  wire logic   receive_data_read_i   = p[6];
  wire logic   receiver_flag_set_i   = p[7];
  int          n_errors, n_tests, cyc, bt;
  int          seed = 47;

  autobaud_wake u_autobaud_wake (.*);
  remote_tx u_remote_tx (.ref_clk_i(ref_clk_i), .line_o(receive_line_i));

  // 20 MHz core clock
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // one-cycle pulse, launched off the sampling edge
  task automatic pulse(input logic [7:0] m);
    @(negedge ref_clk_i) p = m;
    @(negedge ref_clk_i) p = 8'h00;
  endtask

  // nominal count; the tick phase may shift it by one either way
  function automatic logic [15:0] exp_div(input int bt, input logic [1:0] m);
    int unsigned d;
    d = m == 2'b00 ? ABD_DIV_00 : m == 2'b01 ? ABD_DIV_01 : m == 2'b10 ? ABD_DIV_10 : ABD_DIV_11;
    return 16'(1 + 8 * bt / d);
  endfunction

  task automatic measured(input logic [15:0] e);
    logic [15:0] d;
    d = {divider_high_byte_o, divider_low_byte_o};
    check(autobaud_enable_o, 1'b0, "enable after sync");
    check(receive_flag_o, 1'b1, "flag after sync");
    check(d >= e - 16'h0001 && d <= e + 16'h0001, 1'b1, "divider");
    pulse(8'h40);
    check(receive_flag_o, 1'b0, "flag after read");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // hang guard well above the longest run of about 45000 cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    {p, sleep_i, sync_mode_i, wide_divider_select_i, high_speed_select_i} = '0;
    {reset_i, receiver_idle_i, divider_wdata_i} = {2'b11, 16'h0000};
    repeat (12) @(negedge ref_clk_i);
    reset_i = 1'b0;
    check(receive_flag_o, 1'b0, "flag after reset");
    divider_wdata_i = 16'($random(seed));
    pulse(8'h20);
    check({divider_high_byte_o, divider_low_byte_o}, divider_wdata_i, "divider load");
    pulse(8'h80);
    pulse(8'h40);
    check(receive_flag_o, 1'b0, "read clear");
    // every clock mode with a random bit time
    for (int m = 0; m < 4; m++) begin
      {wide_divider_select_i, high_speed_select_i} = 2'(m);
      receiver_idle_i = 1'($random(seed));
      bt = 64 * (8 + int'($unsigned($random(seed)) % 8));
      pulse(8'h01);
      check(receive_hold_idle_o, 1'b1, "hold idle");
      pulse(8'h80);
      check(receive_flag_o, 1'b0, "flag held off");
      u_remote_tx.send(SYNC_CHAR, bt);
      measured(exp_div(bt, 2'(m)));
      check(receive_idle_flag_o, receiver_idle_i, "idle flag");
      if (m < 2) check(divider_high_byte_o, 8'h00, "high byte");
    end
    // wake and measurement armed together: break first, then sync
    pulse(8'h09);
    u_remote_tx.brk(13, 64);
    check(wake_on_break_enable_o, 1'b0, "wake after break");
    check(receive_flag_o, 1'b1, "wake flag");
    pulse(8'h40);
    check(autobaud_enable_o, 1'b1, "still measuring");
    u_remote_tx.send(SYNC_CHAR, 64);
    measured(exp_div(64, 2'b11));
    // non-zero character wakes on its first low stretch
    pulse(8'h08);
    u_remote_tx.send(8'hF0, 64);
    check(wake_on_break_enable_o, 1'b0, "wake after char");
    check(receive_flag_o, 1'b1, "char wake flag");
    pulse(8'h40);
    // asleep: flag must follow the pin before any clock edge
    sleep_i = 1'b1;
    pulse(8'h08);
    fork
      u_remote_tx.brk(13, 64);
      begin
        @(negedge ref_clk_i);
        #5 check(receive_flag_o, 1'b1, "async wake");
      end
    join
    sleep_i = 1'b0;
    pulse(8'h40);
    // sync mode refuses wake; clear pulses
    sync_mode_i = 1'b1;
    pulse(8'h08);
    check(wake_on_break_enable_o, 1'b0, "wake in sync mode");
    sync_mode_i = 1'b0;
    pulse(8'h08);
    pulse(8'h10);
    pulse(8'h01);
    pulse(8'h02);
    check(autobaud_enable_o, 1'b0, "abort");
    pulse(8'h04);
    check(autobaud_overflow_flag_o, 1'b0, "overflow clear");
    conclude();
  end
endmodule
